/* File: hdl/ctx_pkg.sv */
/*
  constants and carrier types of the continuous transmit test control:
  register indices, field positions, reset values, commands and states.
  assumes a single baseband clock domain and an 8-bit register port.
*/
package ctx_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] REG_PHY_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_TX_LEN_LOW  = 3'h1;
  localparam logic [ADDR_W-1:0] REG_TX_LEN_HIGH = 3'h2;
  localparam logic [ADDR_W-1:0] REG_INPHASE_DAC = 3'h3;
  localparam logic [ADDR_W-1:0] REG_QUAD_DAC    = 3'h4;
  localparam logic [ADDR_W-1:0] REG_CHIP_MODE   = 3'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 3'h6;
  localparam logic [ADDR_W-1:0] REG_COMMAND     = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CONTINUOUS_TX_ENABLE_BIT   = 7; // continuous_tx_enable
  localparam int unsigned PC_AFCS_BIT  = 4; // auto_checksum_tx
  localparam int unsigned DAC_EN_BIT   = 7; // override enable
  localparam int unsigned DAC_VAL_W    = 7; // override value, bits 6:0
  localparam int unsigned CHPM_W       = 2; // chip_mode_select
  localparam int unsigned CMD_W        = 3;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0]    PC_RESET    = 8'h00;
  localparam logic [DATA_W-1:0]    DAC_RESET   = 8'h3f;
  localparam logic [DATA_W-1:0]    LEN_RESET   = 8'h00;
  localparam logic [CHPM_W-1:0]    CHPM_RESET  = 2'h0;
  localparam logic [CHPM_W-1:0]    CHPM_CARRIER = 2'h1;
  localparam logic [DAC_VAL_W-1:0] DAC_ZERO    = 7'h3f;

  localparam logic [CMD_W-1:0] CMD_NOP     = 3'h0;
  localparam logic [CMD_W-1:0] CMD_TRX_OFF = 3'h2;
  localparam logic [CMD_W-1:0] CMD_TX_PREP = 3'h3;
  localparam logic [CMD_W-1:0] CMD_TX      = 3'h4;

  localparam int unsigned FCS_OCTETS = 2;
  localparam int unsigned FB_ADDR_W  = 11; // 2 kbyte frame buffer
  localparam int unsigned LEN_W      = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CTX_OFF,
    CTX_PREP,
    CTX_HEADER,
    CTX_PAYLOAD,
    CTX_DRAIN,
    CTX_CARRIER
  } ctx_state_t;

  // one word toward the modulator
  typedef struct packed {
    logic [7:0] data;   // payload octet
    logic       hdr;    // send synchronization and phy header here
    logic       fcs;    // octet is the computed checksum
    logic       last;   // last octet of one repetition
    logic       pad;    // pad bits may follow (final repetition only)
  } ctx_word_t;

  localparam int unsigned WORD_W = $bits(ctx_word_t);

endpackage

/* File: hdl/ctx_top.sv */
/*
  continuous transmit test control for one transceiver: frame based
  continuous transmission from the transmit frame buffer through a
  16-word fifo to the modulator, and override of the i and q dac inputs.
  assumes the frame buffer answers one clock after its address, the
  checksum unit holds the frame checksum on i_fcs, and all inputs share
  i_clk_sys.
*/
`timescale 1ns/100ps

// ------------------------------------------------------------------
// fifo with valid and ready on both sides
// ------------------------------------------------------------------
module ctx_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } ctx_fifo_state_t;

  ctx_fifo_state_t s_r;
  ctx_fifo_state_t s_nxt;
  logic            push;
  logic            pop;

  // honest full and empty from the fill count
  assign o_in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s_r.cnt != '0);
  assign o_out_data  = s_r.mem[s_r.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and count update, flush empties
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = i_in_data;
      s_nxt.wr          = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      s_nxt.wr  = '0;
      s_nxt.rd  = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
module ctx_top
  import ctx_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_resetn,
  input  wire logic                 i_reg_wr,
  input  wire logic [ADDR_W-1:0]    i_reg_addr,
  input  wire logic [DATA_W-1:0]    i_reg_wdata,
  output logic      [DATA_W-1:0]    o_reg_rdata,
  output logic      [FB_ADDR_W-1:0] o_fb_addr,
  output logic                      o_fb_rd,
  input  wire logic [7:0]           i_fb_data,
  input  wire logic [15:0]          i_fcs,
  output logic                      o_tx_valid,
  input  wire logic                 i_tx_ready,
  output ctx_word_t                 o_tx_word,
  input  wire logic [DAC_VAL_W-1:0] i_mod_i,
  input  wire logic [DAC_VAL_W-1:0] i_mod_q,
  output logic      [DAC_VAL_W-1:0] o_dac_i,
  output logic      [DAC_VAL_W-1:0] o_dac_q,
  output logic                      o_tx_on,
  output logic                      o_prep
);

  typedef struct packed {
    ctx_state_t           st;
    logic [DATA_W-1:0]    pc;
    logic [DATA_W-1:0]    len_lo;
    logic [DATA_W-1:0]    len_hi;
    logic [DATA_W-1:0]    daci;
    logic [DATA_W-1:0]    dacq;
    logic [CHPM_W-1:0]    chpm;
    logic [LEN_W-1:0]     cnt;      // next octet to fetch
    logic [LEN_W-1:0]     pos;      // octet being returned
    logic                 pend;     // frame buffer read in flight
    logic [DATA_W-1:0]    rdata;
    logic [FB_ADDR_W-1:0] fb_addr;
    logic                 fb_rd;
    logic                 out_valid;
    ctx_word_t            out_word;
    logic [DAC_VAL_W-1:0] dac_i;
    logic [DAC_VAL_W-1:0] dac_q;
    logic                 tx_on;
    logic                 prep;
  } ctx_state_r_t;

  ctx_state_r_t s_r;
  ctx_state_r_t s_nxt;

  logic       fifo_in_valid;
  logic       fifo_in_ready;
  ctx_word_t  fifo_in_word;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  ctx_word_t  fifo_out_word;
  logic       flush;

  // override mux: enable in bit 7, value in bits 6:0
  function automatic logic [DAC_VAL_W-1:0] dac_pick(
    input logic [DATA_W-1:0]    ovr,
    input logic [DAC_VAL_W-1:0] mod
  );
    dac_pick = ovr[DAC_EN_BIT] ? ovr[DAC_VAL_W-1:0] : mod;
  endfunction

  ctx_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_flush     (flush),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_word)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [LEN_W-1:0] len;
    logic             ctx_en;
    logic             tx_cmd;
    logic             off_cmd;
    s_nxt         = s_r;
    len           = {s_r.len_hi, s_r.len_lo};
    ctx_en        = s_r.pc[CONTINUOUS_TX_ENABLE_BIT];
    tx_cmd        = i_reg_wr && (i_reg_addr == REG_COMMAND) &&
                    (i_reg_wdata[CMD_W-1:0] == CMD_TX);
    off_cmd       = i_reg_wr && (i_reg_addr == REG_COMMAND) &&
                    (i_reg_wdata[CMD_W-1:0] == CMD_TRX_OFF);
    flush         = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_word  = '0;
    s_nxt.fb_rd   = 1'b0;

    // register writes
    if (i_reg_wr) begin
      if (i_reg_addr == REG_PHY_CONTROL) begin
        s_nxt.pc = i_reg_wdata;
      end else if (i_reg_addr == REG_TX_LEN_LOW) begin
        s_nxt.len_lo = i_reg_wdata;
      end else if (i_reg_addr == REG_TX_LEN_HIGH) begin
        s_nxt.len_hi = i_reg_wdata;
      end else if (i_reg_addr == REG_INPHASE_DAC) begin
        s_nxt.daci = i_reg_wdata;
      end else if (i_reg_addr == REG_QUAD_DAC) begin
        s_nxt.dacq = i_reg_wdata;
      end else if (i_reg_addr == REG_CHIP_MODE) begin
        s_nxt.chpm = i_reg_wdata[CHPM_W-1:0];
      end
    end

    // read data, registered
    if (i_reg_addr == REG_PHY_CONTROL) begin
      s_nxt.rdata = s_r.pc;
    end else if (i_reg_addr == REG_TX_LEN_LOW) begin
      s_nxt.rdata = s_r.len_lo;
    end else if (i_reg_addr == REG_TX_LEN_HIGH) begin
      s_nxt.rdata = s_r.len_hi;
    end else if (i_reg_addr == REG_INPHASE_DAC) begin
      s_nxt.rdata = s_r.daci;
    end else if (i_reg_addr == REG_QUAD_DAC) begin
      s_nxt.rdata = s_r.dacq;
    end else if (i_reg_addr == REG_CHIP_MODE) begin
      s_nxt.rdata = DATA_W'(s_r.chpm);
    end else if (i_reg_addr == REG_STATUS) begin
      s_nxt.rdata = DATA_W'(s_r.st);
    end else begin
      s_nxt.rdata = '0;
    end

    // transmit sequencing
    case (s_r.st)
      CTX_OFF: begin
        if (i_reg_wr && (i_reg_addr == REG_COMMAND) &&
            (i_reg_wdata[CMD_W-1:0] == CMD_TX_PREP)) begin
          s_nxt.st = CTX_PREP;
        end
      end
      CTX_PREP: begin
        if (tx_cmd) begin
          if (s_r.chpm == CHPM_CARRIER) begin
            s_nxt.st = CTX_CARRIER;
          end else begin
            s_nxt.st = CTX_HEADER;
          end
        end
      end
      CTX_HEADER: begin
        // header goes out once per transmission
        fifo_in_valid    = 1'b1;
        fifo_in_word.hdr = 1'b1;
        if (fifo_in_ready) begin
          s_nxt.st   = CTX_PAYLOAD;
          s_nxt.cnt  = '0;
          s_nxt.pend = 1'b0;
        end
      end
      CTX_PAYLOAD: begin
        // octet returned by the frame buffer
        if (s_r.pend) begin
          fifo_in_valid = 1'b1;
          fifo_in_word.data = i_fb_data;
          if (s_r.pc[PC_AFCS_BIT] &&
              (s_r.pos >= len - LEN_W'(FCS_OCTETS))) begin
            fifo_in_word.fcs  = 1'b1;
            fifo_in_word.data = (s_r.pos == len - 1'b1) ?
                                i_fcs[15:8] : i_fcs[7:0];
          end
          fifo_in_word.last = (s_r.pos == len - 1'b1);
          fifo_in_word.pad  = fifo_in_word.last && !ctx_en;
          s_nxt.pend = 1'b0;
          if (fifo_in_word.last) begin
            if (ctx_en) begin
              s_nxt.cnt = '0;
            end else begin
              s_nxt.st = CTX_DRAIN;
            end
          end
        end else if (len == '0) begin
          s_nxt.st = CTX_DRAIN;
        end else if (fifo_in_ready && (s_r.cnt < len)) begin
          // one read in flight at most, the fifo has room for it
          s_nxt.fb_addr = s_r.cnt[FB_ADDR_W-1:0];
          s_nxt.fb_rd   = 1'b1;
          s_nxt.pos     = s_r.cnt;
          s_nxt.cnt     = s_r.cnt + 1'b1;
          s_nxt.pend    = 1'b1;
        end
      end
      CTX_DRAIN: begin
        if (!fifo_out_valid && !s_r.out_valid) begin
          s_nxt.st = CTX_PREP;
        end
      end
      CTX_CARRIER: begin
        // carrier runs until transceiver off
        s_nxt.st = CTX_CARRIER;
      end
      default: begin
        s_nxt.st = CTX_OFF;
      end
    endcase

    // transceiver off wins in every state
    if (off_cmd) begin
      s_nxt.st   = CTX_OFF;
      s_nxt.pend = 1'b0;
      s_nxt.fb_rd = 1'b0;
      flush      = 1'b1;
      fifo_in_valid = 1'b0;
    end

    // output stage toward the modulator
    fifo_out_ready = !s_r.out_valid || i_tx_ready;
    if (fifo_out_ready) begin
      s_nxt.out_valid = fifo_out_valid;
      s_nxt.out_word  = fifo_out_word;
    end
    if (off_cmd) begin
      s_nxt.out_valid = 1'b0;
    end

    // dac inputs, each override on its own
    s_nxt.dac_i = dac_pick(s_r.daci, i_mod_i);
    s_nxt.dac_q = dac_pick(s_r.dacq, i_mod_q);
    s_nxt.tx_on = (s_nxt.st == CTX_HEADER) || (s_nxt.st == CTX_PAYLOAD) ||
                  (s_nxt.st == CTX_DRAIN) || (s_nxt.st == CTX_CARRIER);
    s_nxt.prep  = (s_nxt.st == CTX_PREP);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      s_r        <= '0;
      s_r.st     <= CTX_OFF;
      s_r.pc     <= PC_RESET;
      s_r.len_lo <= LEN_RESET;
      s_r.len_hi <= LEN_RESET;
      s_r.daci   <= DAC_RESET;
      s_r.dacq   <= DAC_RESET;
      s_r.chpm   <= CHPM_RESET;
      s_r.dac_i  <= DAC_ZERO;
      s_r.dac_q  <= DAC_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flip-flops
  assign o_reg_rdata = s_r.rdata;
  assign o_fb_addr   = s_r.fb_addr;
  assign o_fb_rd     = s_r.fb_rd;
  assign o_tx_valid  = s_r.out_valid;
  assign o_tx_word   = s_r.out_word;
  assign o_dac_i     = s_r.dac_i;
  assign o_dac_q     = s_r.dac_q;
  assign o_tx_on     = s_r.tx_on;
  assign o_prep      = s_r.prep;

endmodule

/* File: verification/ctx_props.sv */
/*
  port checker of the continuous transmit test control.
  assumes it is bound to ctx_top, with one clock and a synchronous reset.
*/
`timescale 1ns/100ps
module ctx_props
  import ctx_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_resetn,
  input  wire logic                 i_reg_wr,
  input  wire logic [ADDR_W-1:0]    i_reg_addr,
  input  wire logic [DATA_W-1:0]    i_reg_wdata,
  input  wire logic                 o_fb_rd,
  input  wire logic                 o_tx_valid,
  input  wire logic                 i_tx_ready,
  input  wire ctx_word_t            o_tx_word,
  input  wire logic [DAC_VAL_W-1:0] i_mod_i,
  input  wire logic [DAC_VAL_W-1:0] i_mod_q,
  input  wire logic [DAC_VAL_W-1:0] o_dac_i,
  input  wire logic [DAC_VAL_W-1:0] o_dac_q,
  input  wire logic                 o_tx_on,
  input  wire logic                 o_prep
);
  // ----------------------------------------------------------------
  // shadow copies of override and chip mode registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ci_r;
  logic [DATA_W-1:0] cq_r;
  logic [CHPM_W-1:0] cm_r;

  // follow the host writes
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      ci_r <= DAC_RESET;
      cq_r <= DAC_RESET;
      cm_r <= CHPM_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == REG_INPHASE_DAC) ci_r <= i_reg_wdata;
      if (i_reg_addr == REG_QUAD_DAC) cq_r <= i_reg_wdata;
      if (i_reg_addr == REG_CHIP_MODE) cm_r <= i_reg_wdata[CHPM_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence cmd_s(logic [CMD_W-1:0] c);
    i_reg_wr && i_reg_addr == REG_COMMAND && i_reg_wdata[CMD_W-1:0] == c;
  endsequence

  sequence tx_go_s;
    cmd_s(CMD_TX) ##0 o_prep;
  endsequence

  dac_i_ovr_a: assert property ($past(i_resetn) && ci_r == $past(ci_r) |->
    o_dac_i == (ci_r[DAC_EN_BIT] ? ci_r[DAC_VAL_W-1:0] : $past(i_mod_i)))
    else $error("i dac input wrong");
  dac_q_ovr_a: assert property ($past(i_resetn) && cq_r == $past(cq_r) |->
    o_dac_q == (cq_r[DAC_EN_BIT] ? cq_r[DAC_VAL_W-1:0] : $past(i_mod_q)))
    else $error("q dac input wrong");
  tx_start_a: assert property (tx_go_s |=> o_tx_on)
    else $error("tx command did not start");
  hdr_first_a: assert property (tx_go_s ##0 cm_r == CHPM_RESET |->
    ##[3:4] o_tx_valid && o_tx_word.hdr)
    else $error("header word missing");
  prep_off_a: assert property (cmd_s(CMD_TX_PREP) ##0 !o_prep && !o_tx_on
    |=> o_prep)
    else $error("prepare command not taken");
  abort_now_a: assert property (cmd_s(CMD_TRX_OFF) |=>
    !o_tx_on && !o_prep ##[0:1] !o_tx_valid)
    else $error("transceiver off did not abort");
  word_hold_a: assert property (o_tx_valid && !i_tx_ready &&
    !(i_reg_wr && i_reg_addr == REG_COMMAND) |=> o_tx_valid && $stable(o_tx_word))
    else $error("word dropped before taken");
  read_gap_a: assert property (o_fb_rd |=> !o_fb_rd)
    else $error("frame buffer reads too close");
  state_excl_a: assert property (o_prep |-> !o_tx_on)
    else $error("prepare and transmit together");
endmodule

bind ctx_top ctx_props u_ctx_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_fb_rd(o_fb_rd),
  .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_tx_word(o_tx_word),
  .i_mod_i(i_mod_i), .i_mod_q(i_mod_q), .o_dac_i(o_dac_i),
  .o_dac_q(o_dac_q), .o_tx_on(o_tx_on), .o_prep(o_prep)
);

/* File: verification/tb_top.sv */
/*
  self-checking bench of ctx_top: registers, dac override, frames,
  abort with a full fifo and carrier mode.
  assumes the frame buffer modelled here answers within the cycle of
  the read strobe, so its data stands at the next rising edge.
*/
`timescale 1ns/100ps
module tb_top
  import ctx_pkg::*;
;
  logic                 i_clk_sys   = 1'b0;
  logic                 i_resetn    = 1'b0;
  logic                 i_reg_wr    = 1'b0;
  logic [ADDR_W-1:0]    i_reg_addr  = 3'h0;
  logic [DATA_W-1:0]    i_reg_wdata = 8'h00;
  logic [DATA_W-1:0]    o_reg_rdata;
  logic [FB_ADDR_W-1:0] o_fb_addr;
  logic                 o_fb_rd;
  logic [7:0]           i_fb_data   = 8'h00;
  logic [15:0]          i_fcs       = 16'h0000;
  logic                 o_tx_valid;
  logic                 i_tx_ready  = 1'b0;
  ctx_word_t            o_tx_word;
  logic [DAC_VAL_W-1:0] i_mod_i     = 7'h00;
  logic [DAC_VAL_W-1:0] i_mod_q     = 7'h00;
  logic [DAC_VAL_W-1:0] o_dac_i;
  logic [DAC_VAL_W-1:0] o_dac_q;
  logic                 o_tx_on;
  logic                 o_prep;
  logic                 rdy_en      = 1'b0;
  logic [7:0]           mem [2048];
  logic [9:0]           exp_q [$];
  integer               seed        = 32'h3473;
  int                   bad_count   = 0;
  int                   tests_run   = 0;
  int                   hdr_cnt, pad_cnt, taken, n;

  ctx_top #(.FIFO_DEPTH(16)) u_ctx_top (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_fb_addr(o_fb_addr), .o_fb_rd(o_fb_rd),
    .i_fb_data(i_fb_data), .i_fcs(i_fcs), .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready), .o_tx_word(o_tx_word), .i_mod_i(i_mod_i),
    .i_mod_q(i_mod_q), .o_dac_i(o_dac_i), .o_dac_q(o_dac_q),
    .o_tx_on(o_tx_on), .o_prep(o_prep)
  );

  // ----------------------------------------------------------------
  // clock, random drive, frame buffer model
  // ----------------------------------------------------------------
  always #25 i_clk_sys = ~i_clk_sys;

  // modulator samples and ready
  always @(posedge i_clk_sys) begin
    i_mod_i <= 7'($random(seed));
    i_mod_q <= 7'($random(seed));
    i_tx_ready <= rdy_en & 1'($random(seed));
  end

  // buffer answers mid-cycle, data inverted when not read
  always @(negedge i_clk_sys) begin
    i_fb_data <= (o_fb_rd === 1'b1) ? mem[o_fb_addr] : ~i_fb_data;
  end

  // ----------------------------------------------------------------
  // scoreboard and tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // oldest note compared with each non-header word taken, header words counted
  always @(posedge i_clk_sys) begin
    if ((i_resetn & o_tx_valid & i_tx_ready) === 1'b1) begin
      if (o_tx_word.hdr === 1'b1) hdr_cnt++;
      else if (exp_q.size() == 0) check("extra word", 1'b1, 1'b0);
      else begin
        check("tx word", {o_tx_word.data, o_tx_word.fcs, o_tx_word.last},
              exp_q.pop_front());
        taken++;
        if ((o_tx_word.last & o_tx_word.pad) === 1'b1) pad_cnt++;
      end
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("register read", o_reg_rdata, e);
  endtask

  // note the expected words, then program and start a frame
  task automatic start(input logic [7:0] pc, input logic [15:0] len,
                       input int reps);
    logic [15:0] f;
    logic [7:0]  d;
    logic        fl;
    f = 16'($random(seed));
    i_fcs <= f;
    hdr_cnt = 0;
    pad_cnt = 0;
    taken = 0;
    for (int r = 0; r < reps; r++) begin
      for (int i = 0; i < len; i++) begin
        fl = pc[PC_AFCS_BIT] && i >= len - 2;
        d = !fl ? mem[i % 2048] : (i == len - 2) ? f[7:0] : f[15:8];
        exp_q.push_back({d, fl, 1'(i == len - 1)});
      end
    end
    rdy_en <= 1'b1;
    wr(REG_TX_LEN_LOW, len[7:0]);
    wr(REG_TX_LEN_HIGH, len[15:8]);
    wr(REG_PHY_CONTROL, pc);
    wr(REG_COMMAND, {5'h00, CMD_TX_PREP});
    wr(REG_COMMAND, {5'h00, CMD_TX});
  endtask

  // clear the enable, wait for prepare, judge the frame
  task automatic finish(input logic [7:0] pc, input int len, wait_n);
    for (n = 0; n < 5000 && taken < wait_n; n++) @(posedge i_clk_sys);
    wr(REG_PHY_CONTROL, pc & 8'h7f);
    for (n = 0; n < 5000 && o_prep !== 1'b1; n++) @(posedge i_clk_sys);
    check("back to prepare", o_prep, 1'b1);
    check("header count", hdr_cnt, 1);
    check("pad count", pad_cnt, 1);
    check("whole repetitions", taken % len, 0);
    check("repetitions", taken > wait_n, 1'b1);
    exp_q.delete();
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] vi, vq;
    logic [6:0] vals [4];
    int         rds;
    foreach (mem[k]) mem[k] = 8'($random(seed));
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rd(REG_PHY_CONTROL, PC_RESET);
    rd(REG_INPHASE_DAC, DAC_RESET);
    rd(REG_QUAD_DAC, DAC_RESET);
    rd(REG_TX_LEN_HIGH, LEN_RESET);
    wr(REG_STATUS, 8'hff);
    rd(REG_STATUS, 8'h00);
    $display("test registers done");
    vals = '{7'h00, 7'h7e, DAC_ZERO, 7'($random(seed)) % 7'h7f};
    for (int k = 0; k < 4; k++) begin
      vi = {1'(k), vals[k]};
      vq = {1'(k >> 1), vals[3 - k]};
      wr(REG_INPHASE_DAC, vi);
      wr(REG_QUAD_DAC, vq);
      repeat (2) @(negedge i_clk_sys);
      if (vi[7]) check("i dac", o_dac_i, vi[6:0]);
      if (vq[7]) check("q dac", o_dac_q, vq[6:0]);
      rd(REG_INPHASE_DAC, vi);
    end
    $display("test dac override done");
    start(8'h90, 16'h0103, 1);
    finish(8'h90, 259, 0);
    $display("test single checksum frame done");
    start(8'h80, 16'h0005, 8);
    finish(8'h80, 5, 15);
    $display("test repeated frame done");
    start(8'h80, 16'h2f0f, 1);
    rdy_en <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    rds = 0;
    repeat (20) @(posedge i_clk_sys) rds += (o_fb_rd === 1'b1);
    check("reads with full fifo", rds, 0);
    wr(REG_COMMAND, {5'h00, CMD_TRX_OFF});
    repeat (2) @(negedge i_clk_sys);
    check("abort tx on", o_tx_on, 1'b0);
    check("abort valid", o_tx_valid, 1'b0);
    exp_q.delete();
    $display("test abort done");
    wr(REG_CHIP_MODE, {6'h00, CHPM_CARRIER});
    wr(REG_INPHASE_DAC, 8'hfe);
    wr(REG_QUAD_DAC, 8'hbf);
    wr(REG_COMMAND, {5'h00, CMD_TX_PREP});
    wr(REG_COMMAND, {5'h00, CMD_TX});
    rd(REG_STATUS, 8'h05);
    check("carrier on", o_tx_on, 1'b1);
    check("carrier i", o_dac_i, 7'h7e);
    check("carrier q", o_dac_q, DAC_ZERO);
    wr(REG_COMMAND, {5'h00, CMD_TRX_OFF});
    rd(REG_STATUS, 8'h00);
    $display("test carrier done");
    complete_run();
  end
endmodule
